// ==== verilog/event_timer_map.vh ====
// Purpose: Register offsets, field positions and timing counts for the event timer
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz system clock
// Notes:   All offsets are byte addresses of aligned words
`ifndef EVENT_TIMER_MAP_VH
`define EVENT_TIMER_MAP_VH

`define ET_OFF_CTRL       4'h0
`define ET_OFF_TIME       4'h4
`define ET_OFF_STATUS     4'h8
`define ET_OFF_ELAPSED    4'hc

`define ET_MODE_W         3
`define ET_MODE_OFF       3'h0
`define ET_MODE_PULSE     3'h1
`define ET_MODE_DELAY     3'h2
`define ET_MODE_COUNT     3'h3
`define ET_MODE_MINON     3'h4

`define ET_CTRL_INPUT_BIT 3
`define ET_ST_OUT_BIT     0
`define ET_ST_TRIG_BIT    1
`define ET_ST_IN_BIT      2

`define ET_TIME_W         22
`define ET_TIME_MAX       22'h36ee7f
`define ET_SAMPLE_MS      110
`define ET_CLK_MHZ        200
`define ET_TICK_CYCLES    (`ET_SAMPLE_MS * 1000 * `ET_CLK_MHZ)

`define ET_RESP_OKAY      2'h0
`define ET_RESP_SLVERR    2'h2

`endif

// ==== verilog/event_timer.v ====
// Purpose: Four-behaviour event timer with AXI4-Lite register access
// Assumes: Inputs synchronous to CLK_SYS; times held in 110 ms sample ticks
// Notes:   Counting advances only on the 110 ms sample tick
//
// Contract
// - Four selectable timer behaviours
// - Pulse mode: rising input sets output
// - Pulse mode: output low when elapsed reaches time
// - Pulse mode: retrigger clears elapsed, extends pulse
// - Pulse mode: triggered equals output
// - Delay mode: rising input clears output, restarts
// - Delay mode: output high after time, until input low
// - Delay mode: early fall gives one-tick pulse
// - Delay mode: triggered until expired and output low
// - Countdown: nonzero time write sets output
// - Countdown: time decrements to zero, output low
// - Countdown: time may be rewritten anytime
// - Countdown: no reload after reaching zero
// - Countdown: input gates counting and output
// - Countdown: triggered from write until time reaches zero
// - Min-on: rising input sets output
// - Min-on: falling input starts elapsed count
// - Min-on: output low when elapsed equals time
// - Min-on: rising input clears elapsed to zero
// - Min-on: triggered while elapsed above zero
// - Selector encodes off plus four modes
// - Times in 110 ms ticks, max 3599999 ticks
`timescale 1ns/1ps
`include "event_timer_map.vh"

module event_timer #(
  parameter TICK_CYCLES = `ET_TICK_CYCLES
)(
  input  wire        CLK_SYS,
  input  wire        RST_B,
  input  wire        TRIG_IN,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_AWADDR,
  input  wire [2:0]  S_AXI_AWPROT,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  output reg  [1:0]  S_AXI_BRESP,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  input  wire [31:0] S_AXI_ARADDR,
  input  wire [2:0]  S_AXI_ARPROT,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         TIMER_OUT,
  output reg         TRIGGERED,
  output reg  [21:0] ELAPSED
);

  reg  [31:0]               tick_cnt_r;
  reg                       tick_r;
  reg  [`ET_MODE_W-1:0]     mode_r;
  reg                       soft_in_r;
  reg  [`ET_TIME_W-1:0]     time_r;
  reg  [`ET_TIME_W-1:0]     time_nxt;
  reg                       in_prev_r;
  reg                       out_nxt;
  reg                       trig_nxt;
  reg  [`ET_TIME_W-1:0]     elap_nxt;
  reg                       run_r;
  reg                       run_nxt;
  reg                       aw_held_r;
  reg                       w_held_r;
  reg  [3:0]                aw_addr_r;
  reg                       aw_hi_r;
  reg  [31:0]               w_data_r;
  reg  [3:0]                w_strb_r;
  reg                       time_wr;
  reg  [`ET_TIME_W-1:0]     time_wval;
  reg  [31:0]               rd_word;
  reg                       rd_ok;

  wire in_now  = TRIG_IN | soft_in_r;
  wire rise    = in_now & ~in_prev_r;
  wire fall    = ~in_now & in_prev_r;
  wire do_wr   = aw_held_r & w_held_r & ~S_AXI_BVALID;
  // Upper address bits must be zero, or 0x10 would alias the control word
  wire wr_ok   = ~aw_hi_r &
                 ((aw_addr_r == `ET_OFF_CTRL) || (aw_addr_r == `ET_OFF_TIME));
  wire [31:0] wr_merged = {w_strb_r[3] ? w_data_r[31:24] : 8'h00,
                           w_strb_r[2] ? w_data_r[23:16] : 8'h00,
                           w_strb_r[1] ? w_data_r[15:8]  : 8'h00,
                           w_strb_r[0] ? w_data_r[7:0]   : 8'h00};

  // Sample tick from the system clock
  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r == TICK_CYCLES - 1)
    begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r     <= 1'b0;
    end
  end

  // Time value written this cycle, clamped to the settable maximum
  always @*
  begin
    time_wr   = do_wr && wr_ok && (aw_addr_r == `ET_OFF_TIME);
    time_wval = (wr_merged[31:0] > {10'h0, `ET_TIME_MAX}) ? `ET_TIME_MAX
                : wr_merged[`ET_TIME_W-1:0];
  end

  // Behaviour engine
  always @*
  begin
    out_nxt  = TIMER_OUT;
    trig_nxt = TRIGGERED;
    elap_nxt = ELAPSED;
    run_nxt  = run_r;
    time_nxt = time_r;
    if (time_wr)
      time_nxt = time_wval;
    case (mode_r)
      `ET_MODE_PULSE:
      begin
        if (tick_r)
        begin
          if (rise)
          begin
            out_nxt  = 1'b1;
            elap_nxt = {`ET_TIME_W{1'b0}};
          end
          else if (TIMER_OUT)
          begin
            if (ELAPSED + 22'h1 >= time_r)
            begin
              out_nxt  = 1'b0;
              elap_nxt = time_r;
            end
            else
              elap_nxt = ELAPSED + 22'h1;
          end
        end
        trig_nxt = out_nxt;
      end
      `ET_MODE_DELAY:
      begin
        if (tick_r)
        begin
          if (rise)
          begin
            out_nxt  = 1'b0;
            elap_nxt = {`ET_TIME_W{1'b0}};
            run_nxt  = 1'b1;
            trig_nxt = 1'b1;
          end
          else if (run_r)
          begin
            if (ELAPSED + 22'h1 >= time_r)
            begin
              elap_nxt = time_r;
              run_nxt  = 1'b0;
              out_nxt  = 1'b1;
            end
            else
              elap_nxt = ELAPSED + 22'h1;
          end
          // Input still high after expiry keeps the output on
          else if (TIMER_OUT && !in_now)
            out_nxt = 1'b0;
          else if (!TIMER_OUT)
            trig_nxt = 1'b0;
        end
      end
      `ET_MODE_COUNT:
      begin
        // A write wins over a tick in the same cycle; that tick is skipped
        if (time_wr)
        begin
          out_nxt  = (time_wval != 22'h0) & in_now;
          trig_nxt = (time_wval != 22'h0);
        end
        else if (tick_r)
        begin
          if (time_r == 22'h0)
          begin
            out_nxt  = 1'b0;
            trig_nxt = 1'b0;
          end
          else if (in_now)
          begin
            time_nxt = time_r - 22'h1;
            out_nxt  = (time_r != 22'h1);
            trig_nxt = (time_r != 22'h1);
          end
          else
            out_nxt = 1'b0;
        end
        elap_nxt = {`ET_TIME_W{1'b0}};
      end
      `ET_MODE_MINON:
      begin
        if (tick_r)
        begin
          if (rise)
          begin
            out_nxt  = 1'b1;
            elap_nxt = {`ET_TIME_W{1'b0}};
            run_nxt  = 1'b0;
          end
          else if (fall && TIMER_OUT)
            run_nxt = 1'b1;
          if (!rise && (run_r || (fall && TIMER_OUT)))
          begin
            if (ELAPSED + 22'h1 >= time_r)
            begin
              // Elapsed back to zero so the indicator drops with the output
              out_nxt  = 1'b0;
              elap_nxt = {`ET_TIME_W{1'b0}};
              run_nxt  = 1'b0;
            end
            else
              elap_nxt = ELAPSED + 22'h1;
          end
        end
        trig_nxt = (elap_nxt != 22'h0);
      end
      default:
      begin
        out_nxt  = 1'b0;
        trig_nxt = 1'b0;
        elap_nxt = {`ET_TIME_W{1'b0}};
        run_nxt  = 1'b0;
      end
    endcase
  end

  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      TIMER_OUT <= 1'b0;
      TRIGGERED <= 1'b0;
      ELAPSED   <= 22'h0;
      run_r     <= 1'b0;
      time_r    <= 22'h0;
      in_prev_r <= 1'b0;
    end
    else
    begin
      TIMER_OUT <= out_nxt;
      TRIGGERED <= trig_nxt;
      ELAPSED   <= elap_nxt;
      run_r     <= run_nxt;
      time_r    <= time_nxt;
      if (tick_r)
        in_prev_r <= in_now;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `ET_RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 4'h0;
      aw_hi_r       <= 1'b0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      mode_r        <= `ET_MODE_OFF;
      soft_in_r     <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= ~aw_held_r & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY  <= ~w_held_r & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWREADY & S_AXI_AWVALID)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR[3:0];
        aw_hi_r   <= (S_AXI_AWADDR[31:4] != 28'h0);
      end
      if (S_AXI_WREADY & S_AXI_WVALID)
      begin
        w_held_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `ET_RESP_OKAY : `ET_RESP_SLVERR;
        if (wr_ok && (aw_addr_r == `ET_OFF_CTRL))
        begin
          if (w_strb_r[0])
          begin
            // Unused selector codes fall back to off
            mode_r    <= (w_data_r[2:0] > `ET_MODE_MINON) ? `ET_MODE_OFF : w_data_r[2:0];
            soft_in_r <= w_data_r[`ET_CTRL_INPUT_BIT];
          end
        end
      end
      else if (S_AXI_BVALID & S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // Read mux
  always @*
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0;
    case (S_AXI_ARADDR[3:0])
      `ET_OFF_CTRL:    rd_word = {28'h0, soft_in_r, mode_r};
      `ET_OFF_TIME:    rd_word = {10'h0, time_r};
      `ET_OFF_STATUS:  rd_word = {29'h0, in_now, TRIGGERED, TIMER_OUT};
      `ET_OFF_ELAPSED: rd_word = {10'h0, ELAPSED};
      default:         rd_ok   = 1'b0;
    endcase
    // Offsets above the map are refused rather than aliased
    if (S_AXI_ARADDR[31:4] != 28'h0)
    begin
      rd_ok   = 1'b0;
      rd_word = 32'h0;
    end
  end

  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `ET_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARREADY & S_AXI_ARVALID)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_word;
        S_AXI_RRESP  <= rd_ok ? `ET_RESP_OKAY : `ET_RESP_SLVERR;
      end
      else if (S_AXI_RVALID & S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

// ==== tb/event_timer_checker.sv ====
// Purpose: Port-level checks for the event timer
// Assumes: Bench offers CTRL address and data together
// Notes:   Mode is shadowed from bus writes; checks wait for a tick to settle
`timescale 1ns/1ps
module event_timer_checker #(
  parameter TICK_CYCLES = 10
)(
  input wire        CLK_SYS,
  input wire        RST_B,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire [31:0] S_AXI_AWADDR,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire        TIMER_OUT,
  input wire        TRIGGERED,
  input wire [21:0] ELAPSED
);
  reg [2:0] mode_r;
  integer   settle_r;
  wire      wr_hs   = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  wire      settled = settle_r >= TICK_CYCLES + 4;
  // Outputs lag a mode change by up to one tick
  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode_r   <= 3'h0;
      settle_r <= 0;
    end
    else if (wr_hs && S_AXI_AWADDR == 32'h0)
    begin
      mode_r   <= (S_AXI_WDATA[2:0] > 3'h4) ? 3'h0 : S_AXI_WDATA[2:0];
      settle_r <= 0;
    end
    else if (!settled)
      settle_r <= settle_r + 1;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  property p_off; settled && mode_r == 3'h0 |-> !TIMER_OUT && !TRIGGERED && ELAPSED == 22'h0;
  endproperty
  property p_pulse_ind; settled && mode_r == 3'h1 |-> TRIGGERED == TIMER_OUT; endproperty
  property p_minon_ind; settled && mode_r == 3'h4 |-> TRIGGERED == (ELAPSED != 22'h0); endproperty
  property p_cnt_elap; settled && mode_r == 3'h3 |-> ELAPSED == 22'h0; endproperty
  property p_max; ELAPSED <= 22'h36ee7f; endproperty
  property p_bresp; wr_hs |-> ##[1:3] S_AXI_BVALID; endproperty
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  property p_rresp; S_AXI_ARVALID && S_AXI_ARREADY |=> ##[0:2] S_AXI_RVALID; endproperty
  a_off: assert property (p_off) else $error("active while disabled");
  a_pulse_ind: assert property (p_pulse_ind) else $error("indicator differs");
  a_minon_ind: assert property (p_minon_ind) else $error("indicator wrong");
  a_cnt_elap: assert property (p_cnt_elap) else $error("elapsed moved");
  a_max: assert property (p_max) else $error("elapsed over limit");
  a_bresp: assert property (p_bresp) else $error("no write response");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data moved");
  a_rresp: assert property (p_rresp) else $error("no read response");
  c_pulse: cover property (mode_r == 3'h1 && TIMER_OUT);
  c_delay: cover property (mode_r == 3'h2 && TIMER_OUT);
  c_count: cover property (mode_r == 3'h3 && $fell(TIMER_OUT));
  c_minon: cover property (mode_r == 3'h4 && ELAPSED != 22'h0);
endmodule

// ==== tb/trig_source.sv ====
// Purpose: Model of a soft-wired logic source feeding the timer input
// Assumes: Source is a registered level in the same clock domain
// Notes:   Changes only just after a rising edge, like a real block output
`timescale 1ns/1ps
module trig_source (
  input wire clk,
  input wire req,
  output reg level
);
  initial level = 1'b0;
  always @(posedge clk)
    level <= req;
endmodule

// ==== tb/test_four_mode_event_timer.sv ====
// Purpose: Self-checking bench for the event timer
// Assumes: Tick shortened to T clocks so each scenario stays short
// Notes:   Pulse and min-on duration checks allow tick phase slack; the delay pulse width is checked to one clock
`timescale 1ns/1ps
`include "event_timer_map.vh"
module test_four_mode_event_timer;
  localparam T = 10;
  reg        clk_sys = 1'b0;
  reg        rst_b   = 1'b0;
  reg        trig    = 1'b0;
  reg        awv     = 1'b0;
  reg        wv      = 1'b0;
  reg        bready  = 1'b0;
  reg        arv     = 1'b0;
  reg        rready  = 1'b0;
  reg [31:0] awaddr  = 32'h0;
  reg [31:0] wdata   = 32'h0;
  reg [31:0] araddr  = 32'h0;
  reg [31:0] rd;
  reg [1:0]  rsp;
  wire       trig_lvl, awready, wready, bvalid, arready, rvalid, t_out, t_ind;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [21:0] elapsed;
  integer    err_count   = 0;
  integer    comparisons = 0;
  integer    n;
  always #2.5 clk_sys = ~clk_sys;
  trig_source u_src (.clk(clk_sys), .req(trig), .level(trig_lvl));
  event_timer #(.TICK_CYCLES(T)) DUT (.CLK_SYS(clk_sys), .RST_B(rst_b), .TRIG_IN(trig_lvl),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .TIMER_OUT(t_out), .TRIGGERED(t_ind), .ELAPSED(elapsed));
  task check(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // Valids held until each ready is sampled at a rising edge
  task wr(input [31:0] a, input [31:0] d);
  begin
    @(posedge clk_sys);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  end
  endtask
  task rdreg(input [31:0] a);
  begin
    @(posedge clk_sys);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
  end
  endtask
  task wait_out(input v, input integer lim);
  begin
    n = 0;
    while (t_out !== v && n < lim)
    begin
      @(posedge clk_sys);
      n = n + 1;
    end
    check(t_out, v);
  end
  endtask
  task setup(input [2:0] m, input [21:0] t);
  begin
    wr(`ET_OFF_CTRL, {29'h0, m});
    wr(`ET_OFF_TIME, {10'h0, t});
  end
  endtask
  task t_off;
  begin
    check({t_out, t_ind, elapsed}, 24'h0);
    rdreg(32'h10);
    check(rd, 32'h0);
    check(rsp, `ET_RESP_SLVERR);
    wr(32'h10, 32'h1);
    check(rsp, `ET_RESP_SLVERR);
    rdreg(`ET_OFF_CTRL);
    check(rd, {29'h0, `ET_MODE_OFF});
    check(rsp, `ET_RESP_OKAY);
    $display("test off done");
  end
  endtask
  task t_pulse;
  begin
    setup(`ET_MODE_PULSE, 22'h3);
    trig <= 1'b1;
    wait_out(1'b1, 3 * T);
    trig <= 1'b0;
    repeat (2 * T) @(posedge clk_sys);
    trig <= 1'b1;
    wait_out(1'b0, 8 * T);
    check(n >= 2 * T && n <= 5 * T, 1);
    check(elapsed, 22'h3);
    rdreg(`ET_OFF_ELAPSED);
    check(rd, 32'h3);
    trig <= 1'b0;
    $display("test pulse done");
  end
  endtask
  task t_delay;
  begin
    setup(`ET_MODE_DELAY, 22'h3);
    trig <= 1'b1;
    repeat (T + T / 2) @(posedge clk_sys);
    trig <= 1'b0;
    check({t_out, t_ind}, 2'b01);
    wait_out(1'b1, 6 * T);
    wait_out(1'b0, 3 * T);
    check(n >= T - 1 && n <= T + 1, 1);
    repeat (T + 2) @(posedge clk_sys);
    check(t_ind, 1'b0);
    trig <= 1'b1;
    wait_out(1'b1, 6 * T);
    repeat (2 * T) @(posedge clk_sys);
    check(t_out, 1'b1);
    trig <= 1'b0;
    wait_out(1'b0, 3 * T);
    $display("test delay done");
  end
  endtask
  task t_count;
  begin
    wr(`ET_OFF_CTRL, {29'h0, `ET_MODE_COUNT});
    wr(`ET_OFF_TIME, 32'h2);
    repeat (3 * T) @(posedge clk_sys);
    check({t_out, t_ind}, 2'b01);
    rdreg(`ET_OFF_TIME);
    check(rd, 32'h2);
    trig <= 1'b1;
    wait_out(1'b1, 2 * T + 4);
    wait_out(1'b0, 4 * T);
    rdreg(`ET_OFF_TIME);
    check(rd, 32'h0);
    repeat (3 * T) @(posedge clk_sys);
    check({t_out, t_ind}, 2'b00);
    wr(`ET_OFF_TIME, 32'h5);
    repeat (3) @(posedge clk_sys);
    check({t_out, t_ind}, 2'b11);
    rdreg(`ET_OFF_STATUS);
    check(rd, 32'h7);
    wr(`ET_OFF_TIME, 32'h1);
    wait_out(1'b0, 2 * T);
    trig <= 1'b0;
    $display("test countdown done");
  end
  endtask
  task t_minon;
  begin
    setup(`ET_MODE_MINON, 22'h2);
    trig <= 1'b1;
    wait_out(1'b1, 3 * T);
    repeat (2 * T) @(posedge clk_sys);
    check(elapsed, 22'h0);
    trig <= 1'b0;
    wait_out(1'b0, 6 * T);
    check(n >= 2 * T && n <= 3 * T + 2, 1);
    $display("test min-on done");
  end
  endtask
  task give_verdict;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_off;
    t_pulse;
    t_delay;
    t_count;
    t_minon;
    give_verdict;
  end
  initial
  begin
    #100000;
    err_count = err_count + 1;
    give_verdict;
  end
endmodule
bind event_timer event_timer_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .TIMER_OUT(TIMER_OUT), .TRIGGERED(TRIGGERED), .ELAPSED(ELAPSED));
